// file: debug_scan_pkg.sv
/*
  Constants shared by the debug scan chain select block: controller
  states, instruction opcodes, chain numbers, chain layouts and the
  register map of the Avalon-MM slave.
  Assumes the controller state bus uses the encoding given below.
*/
`default_nettype none
package debug_scan_pkg;
  // ==========================================================
  // Instruction opcodes and controller states
  localparam logic [3:0] OP_SCAN_SELECT = 4'h2;
  localparam logic [3:0] OP_INT_TEST    = 4'hc;
  localparam logic [3:0] OP_EXT_TEST    = 4'h0;
  localparam logic [3:0] ST_CAPTURE_DR  = 4'h6;
  localparam logic [3:0] ST_SHIFT_DR    = 4'h2;
  localparam logic [3:0] ST_UPDATE_DR   = 4'h5;
  // ==========================================================
  // Chain numbers and chain layouts
  localparam int         SEL_LEN        = 5;
  localparam logic [4:0] SEL_CAPTURE    = 5'h10;
  localparam logic [4:0] CHAIN_RESERVED = 5'h00;
  localparam logic [4:0] CHAIN_DEBUG    = 5'h01;
  localparam logic [4:0] CHAIN_BKPT     = 5'h02;
  localparam logic [4:0] CHAIN_EXTERNAL = 5'h03;
  localparam logic [4:0] CHAIN_RESET    = 5'h03;
  localparam int         C1_LEN         = 67;
  localparam int         C1_SPEED_BIT   = 32;
  localparam int         C1_WPB_BIT     = 33;
  localparam int         C1_UNUSED_BIT  = 34;
  localparam int         C1_DATA_LSB    = 35;
  localparam int         C2_LEN         = 38;
  localparam int         C2_RW_BIT      = 37;
  localparam int         C2_ADDR_LSB    = 32;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_CONTROL    = 8'h04;
  localparam logic [7:0] REG_BKPT_BASE  = 8'h80;
  localparam int         STAT_DEBUG_BIT = 8;
  localparam int         STAT_SPEED_BIT = 9;
  localparam int         STAT_FIRST_BIT = 10;
  localparam int         CTRL_EXIT_BIT  = 0;
endpackage
`default_nettype wire

// file: debug_scan_select.sv
/*
  Scan path select register, debug chain, breakpoint programming chain,
  external chain routing and core clock enable selection.
  // How it works
  // RULE1: Scan-select instruction in shift-data puts the 5-bit select register in the path.
  // RULE2: Capture-data loads 10000 into the select register.
  // RULE3: Select register shifts out and in least significant bit first.
  // RULE4: Update-data makes the held chain number the active chain.
  // RULE5: Active chain changes only on select update or reset; reset selects 3.
  // RULE6: Active chain number is driven continuously on a 5-bit bus.
  // RULE7: Outside logic builds external chain controls from the shared buses.
  // RULE8: Chains: 0 reserved, 1 debug, 2 breakpoint, 3 external, 16-31 unassigned.
  // RULE9: External chain pins join the path for chain 3 or 16-31.
  // RULE10: Several external chains need an outside multiplexer on the return pin.
  // RULE11: Input cells feed core system or updated value; output cells capture core.
  // RULE12: Debug chain is 67 bits: instruction, speed, watch-plus-break, unused, data.
  // RULE13: Debugger writes zero to bit 34 and ignores it when reading.
  // RULE14: Scanned data feeds core reads; core write data is scanned out.
  // RULE15: Scanned speed bit tells the core to resync to system speed.
  // RULE16: First speed capture after debug entry: low breakpoint, high watchpoint.
  // RULE17: Watch-plus-break bit is set when breakpoint follows watchpoint instruction.
  // RULE18: Debugger selects chain 2, then switches to internal test.
  // RULE19: Chain 2 is 38 bits: write flag 37, address 36-32, data 31-0.
  // RULE20: Chain 2 ignores capture-data and only shifts in shift-data.
  // RULE21: Chain 2 update reads or writes the addressed breakpoint register.
  // RULE22: Core clock enable is system enable normally, debug enable in debug.
  // RULE23: Scan-select opcode is 0010.
  // RULE24: Internal test opcode 1100 connects the active chain in test mode.
  // RULE25: Test data registers move only when debug clock enable is high.
  Assumes the controller, instruction bus and external return pin run on
  clk_sys_in, so they need no synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_scan_select
  import debug_scan_pkg::*;
#(
  parameter int BKPT_REGS = 32
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Controller side
  input  wire logic        debug_clock_enable_in,
  input  wire logic        system_clock_enable_in,
  input  wire logic [3:0]  controller_state_bus_in,
  input  wire logic [3:0]  test_instruction_bus_in,
  input  wire logic        debug_test_data_in,
  input  wire logic        other_register_data_in,
  output logic             debug_test_data_out,
  output logic [4:0]       active_chain_number_bus_out,
  // External chain
  output logic             external_chain_serial_out,
  input  wire logic        external_chain_serial_return_in,
  // Core side
  input  wire logic        debug_entry_in,
  input  wire logic        entry_by_watchpoint_in,
  input  wire logic        watch_plus_break_in,
  input  wire logic [31:0] core_write_data_in,
  input  wire logic [31:0] system_read_data_in,
  output logic [31:0]      core_read_data_out,
  output logic [31:0]      instruction_input_bus_out,
  output logic             system_speed_bit_out,
  output logic             debug_update_out,
  output logic             core_clock_enable_out,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  function automatic logic [31:0] bit_reverse(input logic [31:0] v);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction

  // Chain 3 and all of 16-31 share the one pair of external pins
  function automatic logic is_external(input logic [4:0] n);
    return (n == CHAIN_EXTERNAL) || n[4];
  endfunction

  // ==========================================================
  // Decode of controller state and current instruction
  logic [4:0]        chain_reg;
  logic [SEL_LEN-1:0] select_reg;
  logic [C1_LEN-1:0] chain1_reg;
  logic [C2_LEN-1:0] chain2_reg;
  logic [31:0]       bkpt_mem [BKPT_REGS];
  logic              cap_en;
  logic              shift_en;
  logic              upd_en;
  logic              sel_select;
  logic              sel_chain1;
  logic              sel_chain2;
  logic              sel_ext;

  assign cap_en     = debug_clock_enable_in && controller_state_bus_in == ST_CAPTURE_DR;  // [RULE25]
  assign shift_en   = debug_clock_enable_in && controller_state_bus_in == ST_SHIFT_DR;  // [RULE25]
  assign upd_en     = debug_clock_enable_in && controller_state_bus_in == ST_UPDATE_DR;
  assign sel_select = test_instruction_bus_in == OP_SCAN_SELECT;  // [RULE23]
  assign sel_chain1 = test_instruction_bus_in == OP_INT_TEST && chain_reg == CHAIN_DEBUG;  // [RULE24] [RULE8]
  assign sel_chain2 = test_instruction_bus_in == OP_INT_TEST && chain_reg == CHAIN_BKPT;  // [RULE24] [RULE8]
  assign sel_ext    = (test_instruction_bus_in == OP_INT_TEST || test_instruction_bus_in == OP_EXT_TEST)
                      && is_external(chain_reg);  // [RULE9]

  // ==========================================================
  // Serial return path; the selected register's end bit is a flop
  always_comb begin
    if (sel_select) begin
      debug_test_data_out = select_reg[0];  // [RULE1]
    end else if (sel_chain1) begin
      debug_test_data_out = chain1_reg[C1_LEN-1];
    end else if (sel_chain2) begin
      debug_test_data_out = chain2_reg[0];
    end else if (sel_ext) begin
      debug_test_data_out = external_chain_serial_return_in;  // [RULE9] [RULE10]
    end else begin
      debug_test_data_out = other_register_data_in;
    end
  end

  // Outside logic clocks the external chain from the shared buses
  assign external_chain_serial_out   = debug_test_data_in;  // [RULE7] [RULE9]
  assign active_chain_number_bus_out = chain_reg;  // [RULE6]

  // ==========================================================
  // Scan path select register and active chain
  // Its reset value is never seen: every select scan captures first
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      select_reg <= '0;
    end else if (sel_select && cap_en) begin
      select_reg <= SEL_CAPTURE;  // [RULE2]
    end else if (sel_select && shift_en) begin
      select_reg <= {debug_test_data_in, select_reg[SEL_LEN-1:1]};  // [RULE3]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      chain_reg <= CHAIN_RESET;  // [RULE5]
    end else if (sel_select && upd_en) begin
      chain_reg <= select_reg;  // [RULE4] [RULE5]
    end
  end

  // ==========================================================
  // Debug state, entry cause and core clock qualification
  logic in_debug_reg;
  logic first_capture_reg;
  logic entry_watch_reg;
  logic wpb_reg;
  logic exit_req;

  // Entry beats an exit request in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      in_debug_reg <= 1'b0;
    end else if (debug_entry_in) begin
      in_debug_reg <= 1'b1;
    end else if (exit_req) begin
      in_debug_reg <= 1'b0;
    end
  end

  // Entry set wins over the clear by the first capture
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      first_capture_reg <= 1'b0;
      entry_watch_reg   <= 1'b0;
      wpb_reg           <= 1'b0;
    end else if (debug_entry_in) begin
      first_capture_reg <= 1'b1;
      entry_watch_reg   <= entry_by_watchpoint_in;  // [RULE16]
      wpb_reg           <= watch_plus_break_in;  // [RULE17]
    end else if (sel_chain1 && cap_en) begin
      first_capture_reg <= 1'b0;
    end
  end

  // Combinational, so the switch reaches the core in the flag's own cycle
  assign core_clock_enable_out = in_debug_reg ? debug_clock_enable_in : system_clock_enable_in;  // [RULE22]

  // ==========================================================
  // Debug chain: bit 66 is nearest the serial output
  logic [31:0] rdata_par_reg;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      chain1_reg <= '0;
    end else if (sel_chain1 && cap_en) begin
      chain1_reg[C1_LEN-1:C1_DATA_LSB] <= bit_reverse(core_write_data_in);  // [RULE14] [RULE11]
      chain1_reg[C1_UNUSED_BIT]        <= 1'b0;  // [RULE13]
      chain1_reg[C1_WPB_BIT]           <= wpb_reg;  // [RULE17]
      chain1_reg[C1_SPEED_BIT]         <= first_capture_reg && entry_watch_reg;  // [RULE16]
    end else if (sel_chain1 && shift_en) begin
      chain1_reg <= {chain1_reg[C1_LEN-2:0], debug_test_data_in};  // [RULE12]
    end
  end

  // Parallel registers load only on update, so the core sees a stable word
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_par_reg             <= 32'h0;
      instruction_input_bus_out <= 32'h0;
      system_speed_bit_out      <= 1'b0;
    end else if (sel_chain1 && upd_en) begin
      rdata_par_reg             <= bit_reverse(chain1_reg[C1_LEN-1:C1_DATA_LSB]);  // [RULE14]
      instruction_input_bus_out <= chain1_reg[31:0];  // [RULE12]
      system_speed_bit_out      <= chain1_reg[C1_SPEED_BIT];  // [RULE15]
    end
  end

  // Pulse tells the core a fresh instruction word is ready
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      debug_update_out <= 1'b0;
    end else begin
      debug_update_out <= sel_chain1 && upd_en;
    end
  end

  // Input cell: test mode on the debug chain selects the scanned word
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      core_read_data_out <= 32'h0;
    end else begin
      core_read_data_out <= sel_chain1 ? rdata_par_reg : system_read_data_in;  // [RULE11] [RULE24]
    end
  end

  // ==========================================================
  // Breakpoint programming chain
  logic [4:0] c2_addr;
  assign c2_addr = chain2_reg[C2_RW_BIT-1:C2_ADDR_LSB];

  // Capture leaves chain 2 alone; a read loads data on update for the next shift
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      chain2_reg <= '0;
    end else if (sel_chain2 && shift_en) begin
      chain2_reg <= {debug_test_data_in, chain2_reg[C2_LEN-1:1]};  // [RULE19] [RULE20]
    end else if (sel_chain2 && upd_en && !chain2_reg[C2_RW_BIT]) begin
      chain2_reg[31:0] <= (32'(c2_addr) < BKPT_REGS) ? bkpt_mem[c2_addr] : 32'h0;  // [RULE21]
    end
  end

  // Addresses past BKPT_REGS are dropped, so a smaller unit stays safe
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < BKPT_REGS; i++) begin
        bkpt_mem[i] <= 32'h0;
      end
    end else if (sel_chain2 && upd_en && chain2_reg[C2_RW_BIT] && 32'(c2_addr) < BKPT_REGS) begin
      bkpt_mem[c2_addr] <= chain2_reg[31:0];  // [RULE21] [RULE18]
    end
  end

  // ==========================================================
  // Avalon-MM slave: every access answers one cycle after it is raised
  // Exit lands at the edge that completes the write
  logic ack_reg;
  logic req;
  logic [5:0] bk_index;

  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_reg;
  assign exit_req        = ack_reg && avs_write && avs_address == REG_CONTROL
                           && avs_writedata[CTRL_EXIT_BIT];
  assign bk_index        = avs_address[7:2] - REG_BKPT_BASE[7:2];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_reg) begin
      if (avs_address == REG_STATUS) begin
        avs_readdata <= {21'h0, first_capture_reg, system_speed_bit_out, in_debug_reg, 3'h0, chain_reg};
      end else if (avs_address >= REG_BKPT_BASE && 32'(bk_index) < BKPT_REGS) begin
        avs_readdata <= bkpt_mem[bk_index[4:0]];
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  // ==========================================================
  // Checks
  a_sel_capture: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE2]
    sel_select && cap_en |=> select_reg == SEL_CAPTURE) else $error("select capture wrong");
  a_sel_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE3]
    sel_select && shift_en |=> select_reg[4] == $past(debug_test_data_in)
    && select_reg[3:0] == $past(select_reg[4:1])) else $error("select shift wrong");
  a_sel_path: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE1]
    sel_select |-> debug_test_data_out == select_reg[0]) else $error("select path wrong");

  a_chain_update: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE4]
    sel_select && upd_en |=> chain_reg == $past(select_reg)) else $error("chain update wrong");
  a_chain_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE5]
    !(sel_select && upd_en) |=> $stable(chain_reg)) else $error("chain changed");
  a_chain_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE5]
    $rose(rst_n_in) |-> chain_reg == CHAIN_RESET) else $error("reset chain wrong");

  a_ext_route: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE9]
    sel_ext && !sel_select |-> debug_test_data_out == external_chain_serial_return_in)
    else $error("external route wrong");

  a_speed_first: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE16]
    debug_entry_in ##1 !debug_entry_in ##1 (sel_chain1 && cap_en && !debug_entry_in)
    |=> chain1_reg[C1_SPEED_BIT] == $past(entry_by_watchpoint_in, 3)) else $error("entry cause wrong");
  a_c2_nocap: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE20]
    sel_chain2 && cap_en |=> $stable(chain2_reg)) else $error("chain 2 moved on capture");
  a_c2_write: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE21]
    sel_chain2 && upd_en && chain2_reg[C2_RW_BIT] && c2_addr == 5'h00
    |=> bkpt_mem[0] == $past(chain2_reg[31:0])) else $error("chain 2 write lost");

  a_idle_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE25]
    !debug_clock_enable_in |=> $stable(select_reg) && $stable(chain1_reg) && $stable(chain2_reg))
    else $error("shift without enable");
  a_clk_select: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE22]
    debug_entry_in |=> core_clock_enable_out == debug_clock_enable_in) else $error("clock enable wrong");
  a_bus_answer: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    req && !ack_reg |=> !avs_waitrequest) else $error("bus answer late");
  a_exit_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    exit_req && !debug_entry_in |=> !in_debug_reg) else $error("exit lost");

  // ==========================================================
  // Checks on the debug and breakpoint chains
  a_c1_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE12]
    sel_chain1 && shift_en |=> chain1_reg == {$past(chain1_reg[C1_LEN-2:0]), $past(debug_test_data_in)})
    else $error("chain 1 shift wrong");
  a_c1_capture: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE14]
    sel_chain1 && cap_en |=> chain1_reg[C1_LEN-1:C1_DATA_LSB] == bit_reverse($past(core_write_data_in)))
    else $error("write data capture wrong");
  a_c1_unused: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE13]
    sel_chain1 && cap_en |=> !chain1_reg[C1_UNUSED_BIT]) else $error("unused bit set");
  a_instruction_input_bus_update: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE12]
    sel_chain1 && upd_en |=> instruction_input_bus_out == $past(chain1_reg[31:0])
    && debug_update_out) else $error("instruction update wrong");
  a_speed_update: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE15]
    sel_chain1 && upd_en |=> system_speed_bit_out == $past(chain1_reg[C1_SPEED_BIT]))
    else $error("speed update wrong");
  a_read_word: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE14]
    sel_chain1 && upd_en ##1 sel_chain1
    |=> core_read_data_out == bit_reverse($past(chain1_reg[C1_LEN-1:C1_DATA_LSB], 2))) else $error("read word wrong");

  a_c2_shift: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE20]
    sel_chain2 && shift_en |=> chain2_reg == {$past(debug_test_data_in), $past(chain2_reg[C2_LEN-1:1])})
    else $error("chain 2 shift wrong");
  a_c2_read: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)  // [RULE21]
    sel_chain2 && upd_en && !chain2_reg[C2_RW_BIT] && c2_addr == 5'h00
    |=> chain2_reg[31:0] == $past(bkpt_mem[0])) else $error("chain 2 read lost");

  c_select_update: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) sel_select && upd_en);
  c_chain2_write: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    sel_chain2 && upd_en && chain2_reg[C2_RW_BIT]);
  c_ext_shift: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) sel_ext && shift_en);
  c_chain1_update: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) sel_chain1 && upd_en);
  c_entry_capture: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) debug_entry_in ##2 (sel_chain1 && cap_en));

endmodule
`default_nettype wire

// file: debug_scan_select_tb_top.sv
/*
  Self-checking bench for the scan chain select block.
  Assumes the external chain model stands on the external serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
module debug_scan_select_tb_top;
  import debug_scan_pkg::*;
  logic clk_sys_in, rst_n_in, en, sys_en, tdi, other_in, tdo, ser_out, ser_ret;
  logic entry, by_wp, wpb, upd, cce, speed, av_rd, av_wr, av_wait;
  logic [3:0] st, ins;
  logic [4:0] chain;
  logic [7:0] av_addr;
  logic [31:0] wd, rdin, rdout, ibus, av_wdata, av_rdata, r, a, d;
  logic [66:0] o, s1;
  int seed = 92483;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [4:0] sels [4] = '{5'h00, 5'h1f, 5'h10, 5'h04};
  debug_scan_select u_debug_scan_select (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .debug_clock_enable_in(en), .system_clock_enable_in(sys_en), .controller_state_bus_in(st),
    .test_instruction_bus_in(ins), .debug_test_data_in(tdi), .other_register_data_in(other_in),
    .debug_test_data_out(tdo), .active_chain_number_bus_out(chain), .external_chain_serial_out(ser_out),
    .external_chain_serial_return_in(ser_ret), .debug_entry_in(entry), .entry_by_watchpoint_in(by_wp),
    .watch_plus_break_in(wpb), .core_write_data_in(wd), .system_read_data_in(rdin),
    .core_read_data_out(rdout), .instruction_input_bus_out(ibus), .system_speed_bit_out(speed),
    .debug_update_out(upd), .core_clock_enable_out(cce), .avs_address(av_addr), .avs_read(av_rd),
    .avs_write(av_wr), .avs_writedata(av_wdata), .avs_readdata(av_rdata), .avs_waitrequest(av_wait));
  ext_chain_model u_ext_chain_model (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .debug_clock_enable_in(en), .controller_state_bus_in(st), .test_instruction_bus_in(ins),
    .active_chain_number_bus_in(chain), .serial_in(ser_out), .serial_return_out(ser_ret));
  // ==========================================================
  // Clock, background stimulus and hang guard
  initial begin
    clk_sys_in = 0;
    forever #2 clk_sys_in = !clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    sys_en <= $random(seed);
    other_in <= $random(seed);
    rdin <= $random(seed);
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [66:0] exp, input logic [66:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // ==========================================================
  // Avalon master: holds the request until waitrequest is seen low
  task automatic av(input logic w, input logic [7:0] ad, input logic [31:0] wv, output logic [31:0] rv);
    @(posedge clk_sys_in);
    av_rd <= !w;
    av_wr <= w;
    av_addr <= ad;
    av_wdata <= wv;
    @(posedge clk_sys_in);
    while (av_wait !== 1'b0) @(posedge clk_sys_in);
    rv = av_rdata;
    av_rd <= 0;
    av_wr <= 0;
  endtask
  // Capture, n shifts with random enable gaps, update; bit i of vi goes in i-th
  task automatic scan(input logic [3:0] op, input logic [66:0] vi, input int n, output logic [66:0] vo);
    int i;
    i = 0;
    vo = '0;
    @(posedge clk_sys_in);
    ins <= op;
    st <= ST_CAPTURE_DR;
    en <= 1;
    while (i < n) begin
      @(posedge clk_sys_in);
      st <= ST_SHIFT_DR;
      tdi <= vi[i];
      en <= ($random(seed) % 4 != 0);
      @(negedge clk_sys_in);
      if (en) begin
        vo[i] = tdo;
        i++;
      end
    end
    @(posedge clk_sys_in);
    st <= ST_UPDATE_DR;
    en <= 1;
    @(posedge clk_sys_in);
    st <= 4'hf;
    repeat (2) @(negedge clk_sys_in);
  endtask
  task automatic select(input logic [4:0] n);
    scan(OP_SCAN_SELECT, 67'(n), 5, o);
    check("select_out", 67'h10, 67'(o[4:0]));
    check("chain_bus", 67'(n), 67'(chain));
  endtask
  // Chain 1 vector in shifting order: data, unused zero, flag, speed, instruction
  function automatic logic [66:0] c1_vec(input logic [31:0] in, input logic sp, input logic [31:0] dv);
    logic [66:0] v;
    v = {32'h0, sp, 2'b00, dv};
    for (int k = 0; k < 32; k++) v[35+k] = in[31-k];
    return v;
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n_in, en, sys_en, tdi, other_in, entry, by_wp, wpb, av_rd, av_wr} = '0;
    st = 4'hf;
    ins = OP_EXT_TEST;
    {wd, rdin, av_wdata} = '0;
    av_addr = '0;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1;
    @(negedge clk_sys_in);
    check("reset_chain", 67'(CHAIN_RESET), 67'(chain));
    s1 = {$random(seed), $random(seed), $random(seed)};
    scan(OP_INT_TEST, s1, 16, o);
    check("ext3", 67'(s1[7:0]) << 8, 67'(o[15:0]));
    foreach (sels[k]) select(sels[k]);
    select(5'h11);
    scan(OP_INT_TEST, s1, 12, o);
    check("ext17", 67'(s1[7:0]) << 4, 67'(o[11:0]));
    check("ext_copy", 67'(tdi), 67'(ser_out));
    select(CHAIN_BKPT);
    for (int j = 0; j < 3; j++) begin
      a = (j == 0) ? 32'h0 : $random(seed);
      d = $random(seed);
      scan(OP_INT_TEST, {29'h0, 1'b1, a[4:0], d}, 38, o);
      av(0, REG_BKPT_BASE + {1'b0, a[4:0], 2'b00}, 0, r);
      check("bkpt_write", 67'(d), 67'(r));
      scan(OP_INT_TEST, {29'h0, 1'b0, a[4:0], 32'h0}, 38, o);
      scan(OP_INT_TEST, '0, 38, o);
      check("bkpt_read", 67'(d), 67'(o[31:0]));
    end
    check("chain_kept", 67'(CHAIN_BKPT), 67'(chain));
    av(0, 8'h40, 0, r);
    check("unmapped", 67'h0, 67'(r));
    select(CHAIN_DEBUG);
    wd <= $random(seed);
    @(posedge clk_sys_in);
    {entry, wpb} <= 2'b11;
    by_wp <= 1'($random(seed));
    @(posedge clk_sys_in);
    entry <= 0;
    a = $random(seed);
    d = $random(seed);
    s1 = c1_vec(a, 1'b0, d);
    scan(OP_INT_TEST, s1, 67, o);
    check("wdata", 67'(wd), 67'(o[31:0]));
    check("flags", 67'({by_wp, 1'b1}), 67'(o[34:33]));
    check("instruction_input_bus", 67'(a), 67'(ibus));
    check("speed0", 67'h0, 67'(speed));
    check("rdata", 67'(d), 67'(rdout));
    av(0, REG_STATUS, 0, r);
    check("status", 67'h101, 67'({r[8], 3'h0, r[4:0]}));
    @(negedge clk_sys_in);
    check("clk_en_dbg", 67'(en), 67'(cce));
    scan(OP_INT_TEST, c1_vec(a, 1'b1, d), 67, o);
    check("speed_again", 67'h0, 67'(o[34]));
    check("instruction_input_bus_kept", 67'(s1[66:35]), 67'(o[66:35]));
    check("speed1", 67'h1, 67'(speed));
    av(1, REG_CONTROL, 32'h1, r);
    av(0, REG_STATUS, 0, r);
    check("exit", 67'h0, 67'(r[8]));
    @(negedge clk_sys_in);
    check("clk_en_sys", 67'(sys_en), 67'(cce));
    @(posedge clk_sys_in);
    rst_n_in <= 0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1;
    @(negedge clk_sys_in);
    check("rereset", 67'(CHAIN_RESET), 67'(chain));
    final_report();
  end
endmodule
`default_nettype wire

// file: ext_chain_model.sv
/*
  External scan chains that sit between the external serial pins.
  Assumes the chain number, instruction and state buses come from the block.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_chain_model
  import debug_scan_pkg::*;
#(
  parameter int LEN_A = 8,
  parameter int LEN_B = 4
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  // Shared controls
  input  wire logic       debug_clock_enable_in,
  input  wire logic [3:0] controller_state_bus_in,
  input  wire logic [3:0] test_instruction_bus_in,
  input  wire logic [4:0] active_chain_number_bus_in,
  // Serial pins
  input  wire logic       serial_in,
  output logic            serial_return_out
);
  logic [LEN_A-1:0] chain_a_reg;
  logic [LEN_B-1:0] chain_b_reg;
  logic             toggle_reg;
  logic             shift_ok;
  // ==========================================================
  // Controls decoded from the shared buses
  assign shift_ok = debug_clock_enable_in && controller_state_bus_in == ST_SHIFT_DR &&
                    (test_instruction_bus_in == OP_INT_TEST || test_instruction_bus_in == OP_EXT_TEST);
  always_ff @(posedge clk_sys_in) begin
    toggle_reg <= rst_n_in && !toggle_reg;
    if (!rst_n_in) begin
      chain_a_reg <= '0;
      chain_b_reg <= '0;
    end else if (shift_ok && active_chain_number_bus_in == CHAIN_EXTERNAL) begin
      chain_a_reg <= {serial_in, chain_a_reg[LEN_A-1:1]};
    end else if (shift_ok && active_chain_number_bus_in[4]) begin
      chain_b_reg <= {serial_in, chain_b_reg[LEN_B-1:1]};
    end
  end
  // ==========================================================
  // Return multiplexer; an unselected return toggles so stale data never passes
  assign serial_return_out = (active_chain_number_bus_in == CHAIN_EXTERNAL) ? chain_a_reg[0] :
                             active_chain_number_bus_in[4] ? chain_b_reg[0] : toggle_reg;
endmodule
`default_nettype wire
